// file: gts_pkg.sv
package gts_pkg;

  // ==========================================================================
  // Register map (byte addresses, one 32-bit word each)
  // ==========================================================================
  localparam logic [7:0] OFF_CTRL [3] = '{8'h00, 8'h04, 8'h08};
  localparam logic [7:0] OFF_CNT  [3] = '{8'h0C, 8'h10, 8'h14};
  localparam logic [7:0] OFF_PER  [3] = '{8'h18, 8'h1C, 8'h20};

  // Writable bits of each control register; all others read as zero
  localparam logic [15:0] CTRL_MASK [3] = '{16'hA076, 16'hA07A, 16'hA072};

  // ==========================================================================
  // Values after reset
  // ==========================================================================
  localparam logic [15:0] RST_CTRL   = 16'h0000;
  localparam logic [15:0] RST_COUNT  = 16'h0000;
  localparam logic [15:0] RST_PERIOD = 16'hFFFF;

  // ==========================================================================
  // Prescaler: last count of each ratio (1, 8, 64, 256)
  // ==========================================================================
  localparam logic [7:0] PS_LAST [4] = '{8'h00, 8'h07, 8'h3F, 8'hFF};
  localparam logic [1:0] PS_DIV8 = 2'h1;

  // ==========================================================================
  // Control register layout
  // ==========================================================================
  typedef struct packed {
    logic       runEnable;
    logic       rsv14;
    logic       idleHaltSelect;
    logic [5:0] rsv12to7;
    logic       gateAccumulateEnable;
    logic [1:0] prescaleSelect;
    logic       wideModeSelect;
    logic       extClockSyncSelect;
    logic       clockSourceSelect;
    logic       rsv0;
  } gts_ctrl_t;

endpackage

// file: gts_prescaler.sv
module gts_prescaler #(
  parameter int CW = 8
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       active,
  input  wire logic       baseTick,
  input  wire logic [1:0] prescaleSelect,
  output logic            tick
);

  logic [CW-1:0] divCount;
  logic [CW-1:0] lastCount;

  assign lastCount = CW'(gts_pkg::PS_LAST[prescaleSelect]);
  // Compare with >= so that lowering the ratio mid-count cannot overrun
  assign tick = active && baseTick && (divCount >= lastCount);

  always_ff @(posedge clock) begin
    if (rst || !active) begin
      divCount <= '0;
    end else if (baseTick) begin
      divCount <= (divCount >= lastCount) ? '0 : divCount + CW'(1);
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_prescale_eight: assert property (@(posedge clock) disable iff (rst)
    tick && prescaleSelect == gts_pkg::PS_DIV8
    |=> (!tick || prescaleSelect != gts_pkg::PS_DIV8) [*7])
    else $error("ratio 1:8 ticked early");

endmodule // gts_prescaler

// file: gts_timer_set.sv
// Notes on behaviour
// - Run bit of timer A starts its count; clearing it stops counting.
// - Idle-stop bit set halts the timer during Idle; clear keeps it running.
// - Gate-accumulate bit acts only with the internal clock selected.
// - Prescale codes 0..3 divide the input clock by 1, 8, 64, 256.
// - Timer A sync bit picks synchronised or raw external edges.
// - Timer A source bit: external pin rising edges or instruction clock.
// - Timer B source bit: its own pin rising edges or instruction clock.
// - Timer C source bit: its own pin or the internal clock.
// - Wide bit in timer B control joins B and C into 32 bits.
// - In wide mode B is the low half, C the high half.
// - In wide mode timer B controls, clock and gate drive the pair.
// - In wide mode the match interrupt appears on timer C.
// - In wide mode period is C period high, B period low.
// - The 32-bit timer interrupts when count equals the 32-bit period.
// - B and C alone support all 16-bit modes but asynchronous counting.
// - The converter trigger comes from the B/C pair only.
// - B and C counts are offered as time bases to capture/compare.
// - Unimplemented control bits ignore writes and read zero.
// - Timer A is a timer, synchronous or asynchronous counter.
// - Timer A interrupts on period match or gate falling edge.
//
// The implementer's own choices: register access over AHB-Lite and the address map.
module gts_timer_set (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        cpuIdle,
  input  wire logic        timerAExtClockPin,
  input  wire logic        timerBExtClockPin,
  input  wire logic        timerCExtClockPin,
  input  wire logic        timerAGatePin,
  input  wire logic        timerBGatePin,
  input  wire logic        timerCGatePin,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic             timerAIrq,
  output logic             timerBIrq,
  output logic             timerCIrq,
  output logic             adcTrigger,
  output logic [15:0]      timerBCount,
  output logic [15:0]      timerCCount
);

  // ==========================================================================
  // Bus slave
  // ==========================================================================
  logic        accept;
  logic        wrPend;
  logic        rdPend;
  logic        aHit;
  logic [7:0]  aAddr;
  logic [2:0]  selCtrl;
  logic [2:0]  selCnt;
  logic [2:0]  selPer;
  logic [2:0]  wrCnt;
  logic [31:0] next_hrdata;

  gts_pkg::gts_ctrl_t ctrl [3];
  logic [15:0] per [3];
  logic [15:0] cnt [3];
  logic [15:0] countA;

  // Only whole-word transfers are issued, so hsize needs no decode
  assign accept = hsel && htrans[1] && hready;

  always_ff @(posedge clock) begin
    if (rst) begin
      wrPend <= 1'b0;
      rdPend <= 1'b0;
      aHit   <= 1'b0;
      aAddr  <= 8'h00;
    end else begin
      wrPend <= accept && hwrite;
      rdPend <= accept && !hwrite;
      if (accept) begin
        aHit  <= (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
        aAddr <= haddr[7:0];
      end
    end
  end

  // Reads take one wait state so that a write just before lands first
  always_ff @(posedge clock) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
    end else begin
      hreadyout <= !(accept && !hwrite);
      hresp     <= 1'b0;
      if (rdPend) begin
        hrdata <= next_hrdata;
      end
    end
  end

  always_comb begin
    next_hrdata = 32'h00000000;
    for (int i = 0; i < 3; i++) begin
      selCtrl[i] = aHit && (aAddr == gts_pkg::OFF_CTRL[i]);
      selCnt[i]  = aHit && (aAddr == gts_pkg::OFF_CNT[i]);
      selPer[i]  = aHit && (aAddr == gts_pkg::OFF_PER[i]);
      wrCnt[i]   = wrPend && selCnt[i];
      if (selCtrl[i]) begin
        next_hrdata = {16'h0000, ctrl[i]};
      end
      if (selCnt[i]) begin
        next_hrdata = {16'h0000, cnt[i]};
      end
      if (selPer[i]) begin
        next_hrdata = {16'h0000, per[i]};
      end
    end
  end

  // ==========================================================================
  // Control and period registers
  // ==========================================================================
  always_ff @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (rst) begin
        ctrl[i] <= gts_pkg::gts_ctrl_t'(gts_pkg::RST_CTRL);
      end else if (wrPend && selCtrl[i]) begin
        // Masking drops writes to unimplemented positions
        ctrl[i] <= gts_pkg::gts_ctrl_t'(hwdata[15:0]
                   & gts_pkg::CTRL_MASK[i]);
      end
    end
  end

  always_ff @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (rst) begin
        per[i] <= gts_pkg::RST_PERIOD;
      end else if (wrPend && selPer[i]) begin
        per[i] <= hwdata[15:0];
      end
    end
  end

  // ==========================================================================
  // Pin inputs: three stages, a level counts once stages two and three agree
  // ==========================================================================
  logic [5:0] pinIn;
  logic [5:0] pinS1;
  logic [5:0] pinS2;
  logic [5:0] pinS3;
  logic [5:0] pinLevel;
  logic [5:0] pinPrev;
  logic [5:0] pinRise;
  logic [5:0] pinFall;
  logic       asyncEdgeA;

  assign pinIn = {timerCGatePin, timerBGatePin, timerAGatePin,
                  timerCExtClockPin, timerBExtClockPin, timerAExtClockPin};

  always_ff @(posedge clock) begin
    if (rst) begin
      pinS1    <= 6'h00;
      pinS2    <= 6'h00;
      pinS3    <= 6'h00;
      pinLevel <= 6'h00;
      pinPrev  <= 6'h00;
    end else begin
      pinS1    <= pinIn;
      pinS2    <= pinS1;
      pinS3    <= pinS2;
      pinLevel <= ((pinS2 ~^ pinS3) & pinS3) | ((pinS2 ^ pinS3) & pinLevel);
      pinPrev  <= pinLevel;
    end
  end

  assign pinRise = pinLevel & ~pinPrev;
  assign pinFall = ~pinLevel & pinPrev;
  // Unsynchronised path: raw edge, two cycles sooner, no agreement filter
  assign asyncEdgeA = pinS2[0] && !pinS3[0];

  // ==========================================================================
  // Clock source, gating, idle and prescale per timer
  // ==========================================================================
  logic       wide;
  logic [2:0] extEdge;
  logic [2:0] gated;
  logic [2:0] baseTick;
  logic [2:0] halt;
  logic [2:0] active;
  logic [2:0] tick;
  logic [2:0] match;
  logic [2:0] gateEv;
  logic       hit32;

  assign wide = ctrl[1].wideModeSelect;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      extEdge[i] = pinRise[i];
      // Timer B and C keep no sync bit: they never count asynchronously
      if (i == 0 && !ctrl[0].extClockSyncSelect) begin
        extEdge[i] = asyncEdgeA;
      end
      gated[i] = !ctrl[i].clockSourceSelect
                 && ctrl[i].gateAccumulateEnable;
      baseTick[i] = ctrl[i].clockSourceSelect ? extEdge[i]
                  : (gated[i] ? pinLevel[i+3] : 1'b1);
      halt[i]   = cpuIdle && ctrl[i].idleHaltSelect;
      active[i] = ctrl[i].runEnable && !halt[i];
      gateEv[i] = gated[i] && active[i] && pinFall[i+3];
    end
    if (wide) begin
      // Either idle bit halts the pair, so C's must be clear to run in Idle
      halt[1]   = cpuIdle && (ctrl[1].idleHaltSelect
                  || ctrl[2].idleHaltSelect);
      active[1] = ctrl[1].runEnable && !halt[1];
      gateEv[1] = gated[1] && active[1] && pinFall[4];
      active[2] = 1'b0;
      gateEv[2] = 1'b0;
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_pre
    gts_prescaler #(
      .CW(8)
    ) u_pre (
      .clock          (clock),
      .rst            (rst),
      .active         (active[g]),
      .baseTick       (baseTick[g]),
      .prescaleSelect (ctrl[g].prescaleSelect),
      .tick           (tick[g])
    );
  end

  // ==========================================================================
  // Counters
  // ==========================================================================
  logic [15:0] next_countA;
  logic [15:0] next_timerBCount;
  logic [15:0] next_timerCCount;
  logic [31:0] pairCount;
  logic [31:0] pairPeriod;

  assign cnt[0] = countA;
  assign cnt[1] = timerBCount;
  assign cnt[2] = timerCCount;
  assign pairCount  = {timerCCount, timerBCount};
  assign pairPeriod = {per[2], per[1]};

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      match[i] = tick[i] && (cnt[i] == per[i]);
    end
  end
  assign hit32 = wide && tick[1] && (pairCount == pairPeriod);

  always_comb begin
    next_countA      = countA;
    next_timerBCount = timerBCount;
    next_timerCCount = timerCCount;
    if (tick[0]) begin
      next_countA = match[0] ? 16'h0000 : countA + 16'h0001;
    end
    if (wide) begin
      if (tick[1]) begin
        {next_timerCCount, next_timerBCount} = hit32 ? 32'h00000000
          : pairCount + 32'h00000001;
      end
    end else begin
      if (tick[1]) begin
        next_timerBCount = match[1] ? 16'h0000 : timerBCount + 16'h0001;
      end
      if (tick[2]) begin
        next_timerCCount = match[2] ? 16'h0000 : timerCCount + 16'h0001;
      end
    end
    // Software write wins over a tick in the same cycle
    if (wrCnt[0]) begin
      next_countA = hwdata[15:0];
    end
    if (wrCnt[1]) begin
      next_timerBCount = hwdata[15:0];
    end
    if (wrCnt[2]) begin
      next_timerCCount = hwdata[15:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      countA      <= gts_pkg::RST_COUNT;
      timerBCount <= gts_pkg::RST_COUNT;
      timerCCount <= gts_pkg::RST_COUNT;
    end else begin
      countA      <= next_countA;
      timerBCount <= next_timerBCount;
      timerCCount <= next_timerCCount;
    end
  end

  // ==========================================================================
  // Events
  // ==========================================================================
  always_ff @(posedge clock) begin
    if (rst) begin
      timerAIrq  <= 1'b0;
      timerBIrq  <= 1'b0;
      timerCIrq  <= 1'b0;
      adcTrigger <= 1'b0;
    end else begin
      timerAIrq  <= match[0] || gateEv[0];
      timerBIrq  <= !wide && (match[1] || gateEv[1]);
      timerCIrq  <= wide ? (hit32 || gateEv[1])
                         : (match[2] || gateEv[2]);
      // Timer A has no path to the converter
      adcTrigger <= wide ? hit32 : match[1];
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_run_off_hold: assert property (
    !ctrl[0].runEnable && !wrCnt[0] |=> $stable(countA))
    else $error("timer A moved while stopped");

  a_idle_halt: assert property (
    cpuIdle && ctrl[0].idleHaltSelect && !wrCnt[0] |=> $stable(countA))
    else $error("timer A moved in Idle with halt set");

  a_gate_low_hold: assert property (
    gated[0] && !pinLevel[3] && !wrCnt[0]
    |=> $stable(countA))
    else $error("gated timer A counted with gate low");

  a_wrap_zero: assert property (
    match[0] && !wrCnt[0] |=> countA == 16'h0000)
    else $error("timer A did not wrap at period");

  a_count_step: assert property (
    tick[0] && !match[0] && !wrCnt[0]
    |=> countA == $past(countA) + 16'h0001)
    else $error("timer A step wrong");

  a_match_irq: assert property (
    tick[0] && countA == per[0] |=> timerAIrq)
    else $error("timer A match gave no interrupt");

  a_wide_irq_c: assert property (
    hit32 |=> timerCIrq && !timerBIrq)
    else $error("wide match not on timer C interrupt");

  a_wide_carry: assert property (
    wide && tick[1] && timerBCount == 16'hFFFF && !hit32
    && !wrCnt[1] && !wrCnt[2]
    |=> timerCCount == $past(timerCCount) + 16'h0001 && timerBCount == 0)
    else $error("low half carry lost");

  a_adc_pair_only: assert property (
    adcTrigger |-> $past(tick[1]))
    else $error("converter trigger without pair tick");

  a_read_wait: assert property (
    accept && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  c_wide_match: cover property (hit32);
  c_gate_fall: cover property (gateEv[0]);
  c_async_edge: cover property (tick[0] && !ctrl[0].extClockSyncSelect
                                && ctrl[0].clockSourceSelect);
  c_adc_trigger: cover property (adcTrigger && wide);

endmodule // gts_timer_set

// file: gts_pin_model.sv
// ==========================================================================
// External count clock pins
// ==========================================================================
module gts_pin_model (
  input  wire logic        clock,
  input  wire logic [2:0]  pinRun,
  output logic [2:0]       extPins,
  output logic [2:0][15:0] edgesMade
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] phase = 2'h0;

  initial extPins = 3'h0;
  initial edgesMade = '0;

  // Eight clocks a period keeps each level past the pin filter; a pin
  // stands low while idle, and a started pulse is always completed
  always @(posedge clock) begin
    phase <= phase + 2'h1;
    for (int i = 0; i < 3; i++) begin
      if (phase == 2'h3 && (pinRun[i] || extPins[i])) begin
        extPins[i] <= !extPins[i];
        if (!extPins[i]) edgesMade[i] <= edgesMade[i] + 16'h0001;
      end
    end
  end
endmodule // gts_pin_model

// file: tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] RUN = 16'h8000;
  localparam logic [15:0] IDL = 16'h2000;
  localparam logic [15:0] GAT = 16'h0040;
  localparam logic [15:0] WID = 16'h0008;
  localparam logic [15:0] SYN = 16'h0004;
  localparam logic [15:0] SRC = 16'h0002;

  logic              clock = 1'b0;
  logic              rst = 1'b1;
  logic              cpuIdle = 1'b0;
  logic              hsel = 1'b0;
  logic              hwrite = 1'b0;
  logic [31:0]       haddr = 32'h0;
  logic [31:0]       hwdata = 32'h0;
  logic [1:0]        htrans = 2'h0;
  logic [2:0]        hsize = 3'h2;
  logic [2:0]        gatePins = 3'h0;
  logic [2:0]        pinRun = 3'h0;
  logic [2:0]        extPins;
  logic [2:0][15:0]  edgesMade;
  logic [31:0]       hrdata;
  logic              hready, hreadyout, hresp, adcTrigger;
  logic              timerAIrq, timerBIrq, timerCIrq;
  logic [15:0]       timerBCount, timerCCount;
  logic [3:0]        events;
  int                fails = 0;
  int                comparisons = 0;

  assign hready = hreadyout;
  assign events = {adcTrigger, timerCIrq, timerBIrq, timerAIrq};

  gts_timer_set dut (
    .clock, .rst, .cpuIdle, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hrdata, .hresp, .timerAIrq,
    .timerBIrq, .timerCIrq, .adcTrigger, .timerBCount, .timerCCount,
    .timerAExtClockPin(extPins[0]), .timerBExtClockPin(extPins[1]),
    .timerCExtClockPin(extPins[2]), .timerAGatePin(gatePins[0]),
    .timerBGatePin(gatePins[1]), .timerCGatePin(gatePins[2]));

  gts_pin_model pins (.clock(clock), .pinRun(pinRun), .extPins(extPins),
    .edgesMade(edgesMade));

  initial forever #4 clock = ~clock;

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input logic [31:0] seen, exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic waitReady;
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      fails++;
      $display("BAD %0t bus never ready", $time);
      results();
    end
  endtask

  // Entered just after a rising edge; holds each phase until ready
  task automatic busXfer(input logic [7:0] a, input logic wr,
                         input logic [15:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    waitReady();
    q = hrdata;
  endtask

  task automatic regWrite(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    busXfer(a, 1'b1, d, q);
  endtask

  task automatic regRead(input logic [7:0] a, output logic [31:0] q);
    busXfer(a, 1'b0, 16'h0, q);
  endtask

  task automatic setTimer(input int t, input logic [15:0] per, cnt, ctl);
    regWrite(gts_pkg::OFF_PER[t], per);
    regWrite(gts_pkg::OFF_CNT[t], cnt);
    regWrite(gts_pkg::OFF_CTRL[t], ctl);
  endtask

  // Counts cycles up to a pulse on one event line, gathering all others
  task automatic waitEvent(input int sel, output int cyc,
                           output logic [3:0] seen);
    cyc = 0;
    seen = 4'h0;
    do begin
      @(posedge clock);
      cyc++;
      seen |= events;
    end while (events[sel] !== 1'b1 && cyc < 2000);
    if (events[sel] !== 1'b1) begin
      fails++;
      $display("BAD %0t event %0d missing", $time, sel);
      results();
    end
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic testRegs;
    logic [31:0] q;
    for (int i = 0; i < 3; i++) begin
      regRead(gts_pkg::OFF_CTRL[i], q);
      check(q, {16'h0, gts_pkg::RST_CTRL}, "ctrl reset");
      regRead(gts_pkg::OFF_CNT[i], q);
      check(q, {16'h0, gts_pkg::RST_COUNT}, "count reset");
      regRead(gts_pkg::OFF_PER[i], q);
      check(q, {16'h0, gts_pkg::RST_PERIOD}, "period reset");
      regWrite(gts_pkg::OFF_CTRL[i], 16'h7FFF);
      regRead(gts_pkg::OFF_CTRL[i], q);
      check(q, {16'h0, 16'h7FFF & gts_pkg::CTRL_MASK[i]}, "ctrl mask");
      regWrite(gts_pkg::OFF_CTRL[i], 16'h0000);
    end
    regWrite(8'h24, 16'hFFFF);
    regRead(8'h24, q);
    check(q, 32'h0, "unmapped read");
    check(hresp, 1'b0, "response");
    $display("test regs done");
  endtask

  task automatic testPrescale;
    int divs[4] = '{1, 8, 64, 256};
    int cyc;
    logic [3:0] seen;
    for (int p = 0; p < 4; p++) begin
      regWrite(gts_pkg::OFF_CTRL[1], 16'h0000);
      setTimer(1, 16'h0001, 16'h0000, RUN | (16'(p) << 4));
      waitEvent(1, cyc, seen);
      waitEvent(1, cyc, seen);
      check(cyc, 2 * divs[p], "prescaled period");
      check(seen, 4'hA, "timer B events");
    end
    $display("test prescale done");
  endtask

  task automatic testIdleStop;
    logic [15:0] c;
    logic [31:0] q;
    setTimer(1, 16'hFFFF, 16'h0000, RUN | IDL);
    cpuIdle <= 1'b1;
    repeat (8) @(posedge clock);
    c = timerBCount;
    repeat (20) @(posedge clock);
    check(timerBCount, c, "halted in idle");
    regWrite(gts_pkg::OFF_CTRL[1], RUN);
    // The write lands on the edge the task returns at; step past it
    @(posedge clock);
    c = timerBCount;
    repeat (20) @(posedge clock);
    check(timerBCount - c, 16'd20, "runs in idle");
    cpuIdle <= 1'b0;
    regWrite(gts_pkg::OFF_CTRL[1], 16'h0000);
    @(posedge clock);
    c = timerBCount;
    repeat (20) @(posedge clock);
    check(timerBCount, c, "stopped");
    regRead(gts_pkg::OFF_CNT[1], q);
    check(q, {16'h0, timerBCount}, "time base");
    $display("test idle stop done");
  endtask

  task automatic testGate;
    int cyc;
    logic [3:0] seen;
    logic [31:0] q;
    setTimer(0, 16'hFFFF, 16'h0000, RUN | GAT);
    repeat (30) @(posedge clock);
    regRead(gts_pkg::OFF_CNT[0], q);
    check(q, 32'h0, "gate low holds");
    gatePins[0] <= 1'b1;
    repeat (40) @(posedge clock);
    gatePins[0] <= 1'b0;
    waitEvent(0, cyc, seen);
    check(seen[3], 1'b0, "no trigger from A");
    regRead(gts_pkg::OFF_CNT[0], q);
    check(q, 32'd40, "gated count");
    regWrite(gts_pkg::OFF_CTRL[0], 16'h0000);
    $display("test gate done");
  endtask

  // Timer A twice: synchronised, then raw edges; the gate bit is set
  // with the gate low to show it is ignored on an external clock
  task automatic testExt;
    int t;
    logic [15:0] e;
    logic [31:0] q;
    for (int i = 0; i < 4; i++) begin
      t = i % 3;
      setTimer(t, 16'hFFFF, 16'h0000,
               RUN | SRC | GAT | (i == 0 ? SYN : 16'h0000));
      e = edgesMade[t];
      pinRun[t] <= 1'b1;
      repeat (160) @(posedge clock);
      pinRun[t] <= 1'b0;
      repeat (24) @(posedge clock);
      regRead(gts_pkg::OFF_CNT[t], q);
      check(q, {16'h0, edgesMade[t] - e}, "external edges");
      regWrite(gts_pkg::OFF_CTRL[t], 16'h0000);
    end
    $display("test external done");
  endtask

  task automatic testWide;
    int cyc, n;
    logic [3:0] seen;
    regWrite(gts_pkg::OFF_CTRL[2], 16'h0030);
    regWrite(gts_pkg::OFF_CTRL[1], WID);
    regWrite(gts_pkg::OFF_PER[2], 16'h0001);
    setTimer(1, 16'h0001, 16'hFFFD, WID);
    regWrite(gts_pkg::OFF_CNT[2], 16'h0000);
    regWrite(gts_pkg::OFF_CTRL[1], RUN | WID);
    n = 0;
    while (timerCCount !== 16'h0001 && n < 50) begin
      @(posedge clock);
      n++;
    end
    if (timerCCount !== 16'h0001) begin
      fails++;
      $display("BAD %0t carry never came", $time);
      results();
    end
    check(timerBCount, 16'h0000, "carry into high half");
    check(timerCCount, 16'h0001, "high half");
    waitEvent(2, cyc, seen);
    check(seen, 4'hC, "wide events");
    regWrite(gts_pkg::OFF_CTRL[1], WID);
    regWrite(gts_pkg::OFF_PER[2], 16'h0000);
    setTimer(1, 16'h0003, 16'h0000, WID);
    regWrite(gts_pkg::OFF_CNT[2], 16'h0000);
    regWrite(gts_pkg::OFF_CTRL[1], RUN | WID);
    waitEvent(2, cyc, seen);
    waitEvent(2, cyc, seen);
    check(cyc, 4, "wide period");
    cpuIdle <= 1'b1;
    waitEvent(2, cyc, seen);
    check(cyc, 4, "wide runs in idle");
    cpuIdle <= 1'b0;
    regWrite(gts_pkg::OFF_CTRL[1], 16'h0000);
    $display("test wide done");
  endtask

  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    testRegs();
    testPrescale();
    testIdleStop();
    testGate();
    testExt();
    testWide();
    results();
  end
endmodule // tb_top
